// ---- core/add_alu_map.vh ----
`ifndef ADD_ALU_MAP_VH
`define ADD_ALU_MAP_VH

// ==========================================================================
// flag register bit positions
`define FLG_CARRY      0
`define FLG_DEBUG      1
`define FLG_ZERO       2
`define FLG_SIGN       3
`define FLG_BANK       4
`define FLG_OVERFLOW   5
`define FLG_INT_EN     6
`define FLG_STACK_SEL  7
`define FLAGS_RESET    8'h00

// ==========================================================================
// operand kinds (3 bits)
`define KIND_DATA_REG  3'h0
`define KIND_ADDR_REG  3'h1
`define KIND_MEMORY    3'h2
`define KIND_IMMEDIATE 3'h3
`define KIND_STACK_PTR 3'h4

// ==========================================================================
// instruction formats (2 bits)
`define FMT_GENERIC    2'h0
`define FMT_QUICK      2'h1
`define FMT_SHORT      2'h2

// ==========================================================================
// memory sub-modes, only dsp8 and abs16 allowed in short format (2 bits)
`define MEM_DSP8       2'h0
`define MEM_ABS16      2'h1
`define MEM_OTHER      2'h2

// ==========================================================================
// low-bank byte register ids usable in short format (3 bits)
`define REG_LOW_BYTE0  3'h0
`define REG_LOW_BYTE1  3'h1

// ==========================================================================
// quick immediate range
`define QUICK_IMM_MIN  (-8)
`define QUICK_IMM_MAX  7

`endif

// ---- core/add_flag_unit.v ----
`timescale 1ns/10ps
`default_nettype none

module add_flag_unit
(
    input  wire [15:0] opnd_a,
    input  wire [15:0] opnd_b,
    input  wire        carry_in,
    input  wire        wide,
    output reg  [15:0] sum,
    output reg         ovf,
    output reg         sgn,
    output reg         zro,
    output reg         cry
);

    reg [16:0] full;

    // ======================================================================
    // adder with flags at the selected width
    always @*
    begin
        full = {1'b0, opnd_a} + {1'b0, opnd_b} + {16'h0000, carry_in};
        if (wide)
        begin
            sum = full[15:0];
            ovf = (opnd_a[15] == opnd_b[15]) && (full[15] != opnd_a[15]);
            sgn = full[15];
            zro = (full[15:0] == 16'h0000);
            cry = full[16];
        end
        else
        begin
            sum = {8'h00, full[7:0]};
            ovf = (opnd_a[7] == opnd_b[7]) && (full[7] != opnd_a[7]);
            sgn = full[7];
            zro = (full[7:0] == 8'h00);
            cry = full[8] ^ opnd_a[8] ^ opnd_b[8];
        end
    end

endmodule
`default_nettype wire

// ---- core/add_carry_alu_ops.v ----
// Summary of operation
// [RL1] carry-only add: destination plus carry flag
// [RL2] plain add: source plus destination, no carry
// [RL3] byte add to address register: zero-extend, 16-bit
// [RL4] byte add from address register: low byte
// [RL5] byte add to stack pointer: sign-extend source
// [RL6] stack add uses selected pointer, immediate only
// [RL7] overflow on signed range exceed per size
// [RL8] sign equals result top bit per size
// [RL9] zero set when result is zero
// [RL10] carry on unsigned range exceed per size
// [RL11] byte add: not both operands address registers
// [RL12] quick immediate limited to -8..+7
// [RL13] short format is byte size only
// [RL14] short: distinct low-bank regs, dsp8, abs16
// [RL15] only overflow, sign, zero, carry change

`timescale 1ns/10ps
`default_nettype none
`include "add_alu_map.vh"

module add_carry_alu_ops
(
    input  wire        clk,
    input  wire        rst_n,
    // operation request and its operands
    input  wire        op_valid,
    input  wire        op_carry_only,
    input  wire        op_byte,
    input  wire [1:0]  op_format,
    input  wire [2:0]  src_kind,
    input  wire [2:0]  src_reg_id,
    input  wire [1:0]  src_mem_mode,
    input  wire [15:0] src_value,
    input  wire [2:0]  dst_kind,
    input  wire [2:0]  dst_reg_id,
    input  wire [1:0]  dst_mem_mode,
    input  wire [15:0] dst_value,
    // current core state
    input  wire [15:0] user_sp_in,
    input  wire [15:0] int_sp_in,
    input  wire [7:0]  flags_in,
    // registered answer
    output reg  [15:0] result_q,
    output reg         result_valid_q,
    output reg         wr_user_sp_q,
    output reg         wr_int_sp_q,
    output reg  [7:0]  flags_q,
    output reg         op_refused_q
);

    // ======================================================================
    // short-format operand: low-bank byte reg, dsp8 or abs16 memory
    function is_short_ok;
        input [2:0] kind;
        input [2:0] reg_id;
        input [1:0] mem_mode;
        begin
            case (kind)
                `KIND_DATA_REG:
                    is_short_ok = (reg_id == `REG_LOW_BYTE0) ||
                                  (reg_id == `REG_LOW_BYTE1);
                `KIND_MEMORY:
                    is_short_ok = (mem_mode == `MEM_DSP8) ||
                                  (mem_mode == `MEM_ABS16);
                default:
                    is_short_ok = 1'b0;
            endcase
        end
    endfunction

    // ======================================================================
    // quick immediate fits -8..+7 when all bits above bit 2 agree
    // byte size looks at bits 7:3 only, the upper byte is ignored
    function quick_in_range;
        input [15:0] v;
        input        byte_sz;
        begin
            if (byte_sz)
                quick_in_range = (v[7:3] == 5'h00) || (v[7:3] == 5'h1f);
            else
                quick_in_range = (v[15:3] == 13'h0000) ||
                                 (v[15:3] == 13'h1fff);
        end
    endfunction

    // ======================================================================
    // operand legality
    // a refused op shows only as a refusal pulse, nothing else moves
    reg  dst_is_sp;
    reg  dst_is_addr;
    reg  refuse;
    always @*
    begin
        dst_is_sp   = (dst_kind == `KIND_STACK_PTR);
        dst_is_addr = (dst_kind == `KIND_ADDR_REG);
        refuse      = 1'b0;
        if (!op_carry_only)
        begin
            if (op_byte && dst_is_addr && src_kind == `KIND_ADDR_REG)
                refuse = 1'b1;                          // [RL11]
            if (dst_is_sp && src_kind != `KIND_IMMEDIATE)
                refuse = 1'b1;                          // [RL6]
            if (op_format == `FMT_QUICK &&
                (src_kind != `KIND_IMMEDIATE ||
                 !quick_in_range(src_value, op_byte)))
                refuse = 1'b1;                          // [RL12]
            if (op_format == `FMT_SHORT)
            begin
                if (!op_byte)
                    refuse = 1'b1;                      // [RL13]
                if (!is_short_ok(dst_kind, dst_reg_id, dst_mem_mode))
                    refuse = 1'b1;                      // [RL14]
                if (src_kind != `KIND_IMMEDIATE &&
                    !is_short_ok(src_kind, src_reg_id, src_mem_mode))
                    refuse = 1'b1;                      // [RL14]
                if (src_kind == `KIND_DATA_REG &&
                    dst_kind == `KIND_DATA_REG &&
                    src_reg_id == dst_reg_id)
                    refuse = 1'b1;                      // [RL14]
            end
        end
        // carry-only has no source: only target and format can fail
        else if (dst_is_sp || op_format != `FMT_GENERIC)
            refuse = 1'b1;
        // code 3 names no format and is always refused
        if (op_format != `FMT_GENERIC && op_format != `FMT_QUICK &&
            op_format != `FMT_SHORT)
            refuse = 1'b1;
    end

    // ======================================================================
    // operand shaping
    reg  [15:0] opnd_a;
    reg  [15:0] opnd_b;
    reg         carry_in;
    reg         wide;
    always @*
    begin
        // byte adds into an address reg or stack pointer run at 16 bits
        wide = !op_byte || dst_is_addr || dst_is_sp;    // [RL3] [RL5]
        // the stack-select flag picks the pointer read and written back
        if (dst_is_sp)
            opnd_a = flags_in[`FLG_STACK_SEL] ? user_sp_in
                                              : int_sp_in;  // [RL6]
        else
            opnd_a = dst_value;
        // carry-only: the carry flag is the whole second operand
        if (op_carry_only)
        begin
            opnd_b   = 16'h0000;                        // [RL1]
            carry_in = flags_in[`FLG_CARRY];            // [RL1]
        end
        else
        begin
            // plain add never reads the incoming carry flag
            carry_in = 1'b0;                            // [RL2]
            if (!op_byte)
                opnd_b = src_value;
            else if (dst_is_sp)
                opnd_b = {{8{src_value[7]}}, src_value[7:0]};   // [RL5]
            else
                opnd_b = {8'h00, src_value[7:0]};       // [RL3] [RL4]
        end
    end

    // ======================================================================
    // shared adder, flags taken at the width chosen above
    wire [15:0] sum;
    wire        ovf;
    wire        sgn;
    wire        zro;
    wire        cry;

    add_flag_unit u_add
    (
        .opnd_a   (opnd_a),
        .opnd_b   (opnd_b),
        .carry_in (carry_in),
        .wide     (wide),
        .sum      (sum),
        .ovf      (ovf),
        .sgn      (sgn),
        .zro      (zro),
        .cry      (cry)
    );

    // ======================================================================
    // result and flag registers
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            // everything starts cleared, flags at their reset value
            result_q       <= 16'h0000;
            result_valid_q <= 1'b0;
            wr_user_sp_q   <= 1'b0;
            wr_int_sp_q    <= 1'b0;
            flags_q        <= `FLAGS_RESET;
            op_refused_q   <= 1'b0;
        end
        else
        begin
            // pulses are rewritten every cycle, so each stands one cycle
            result_valid_q <= op_valid && !refuse;
            op_refused_q   <= op_valid && refuse;
            wr_user_sp_q   <= op_valid && !refuse && dst_is_sp &&
                              flags_in[`FLG_STACK_SEL];          // [RL6]
            wr_int_sp_q    <= op_valid && !refuse && dst_is_sp &&
                              !flags_in[`FLG_STACK_SEL];         // [RL6]
            // result and flags hold until the next accepted op
            if (op_valid && !refuse)
            begin
                result_q <= sum;                        // [RL1] [RL2]
                // flags the add does not own pass through unchanged
                flags_q  <= flags_in;                   // [RL15]
                flags_q[`FLG_OVERFLOW] <= ovf;          // [RL7]
                flags_q[`FLG_SIGN]     <= sgn;          // [RL8]
                flags_q[`FLG_ZERO]     <= zro;          // [RL9]
                flags_q[`FLG_CARRY]    <= cry;          // [RL10]
            end
        end
    end

endmodule
`default_nettype wire

// ---- tb/add_alu_props.sv ----
`timescale 1ns/10ps
`default_nettype none

// ==========================================
// port relations of the add datapath
module add_alu_props
(
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        op_valid,
    input wire logic        op_carry_only,
    input wire logic        op_byte,
    input wire logic [1:0]  op_format,
    input wire logic [2:0]  src_kind,
    input wire logic [15:0] src_value,
    input wire logic [2:0]  dst_kind,
    input wire logic [15:0] dst_value,
    input wire logic [7:0]  flags_in,
    input wire logic [15:0] result_q,
    input wire logic        result_valid_q,
    input wire logic        wr_user_sp_q,
    input wire logic        wr_int_sp_q,
    input wire logic [7:0]  flags_q,
    input wire logic        op_refused_q
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    // accepted request followed by its answer
    sequence taken;
        op_valid ##1 result_valid_q;
    endsequence

    // word immediate added to a data register
    wire plain_w = op_valid && !op_carry_only && !op_byte
        && op_format == 2'h0 && src_kind == 3'h3 && dst_kind == 3'h0;

    a_plain_sum: assert property (plain_w |=>
        {flags_q[0], result_q} == {1'b0, $past(src_value)}
        + $past(dst_value)) else $error("bad sum");
    a_carry_only: assert property (op_valid && op_carry_only
        && !op_byte && op_format == 2'h0 && dst_kind == 3'h0
        |=> result_q == $past(dst_value) + $past(flags_in[0]))
        else $error("bad carry add");
    a_zero_flag: assert property (result_valid_q
        |-> flags_q[2] == (result_q == 16'h0000)) else $error("bad zero");
    a_sign_word: assert property (result_valid_q && !$past(op_byte)
        |-> flags_q[3] == result_q[15]) else $error("bad sign");
    a_keep_flags: assert property (taken |-> flags_q[7:6] ==
        $past(flags_in[7:6]) && flags_q[4] == $past(flags_in[4])
        && flags_q[1] == $past(flags_in[1])) else $error("flag changed");
    a_sp_select: assert property (op_valid && dst_kind == 3'h4
        ##1 result_valid_q |-> wr_user_sp_q == $past(flags_in[7])
        && wr_int_sp_q != $past(flags_in[7])) else $error("bad sp");
    a_quick_range: assert property (op_valid && op_format == 2'h1
        && !op_byte && src_value[15:3] != 13'h0000
        && src_value[15:3] != 13'h1fff |=> op_refused_q)
        else $error("quick range");
    a_short_word: assert property (op_valid && op_format == 2'h2
        && !op_byte |=> op_refused_q && !result_valid_q)
        else $error("short word");
    a_byte_addr: assert property (op_valid && op_byte
        && !op_carry_only && src_kind == 3'h1 && dst_kind == 3'h1
        |=> op_refused_q)
        else $error("addr pair");
endmodule

bind add_carry_alu_ops add_alu_props chk_u (.*);

`default_nettype wire

// ---- tb/testbench.sv ----
`timescale 1ns/10ps
`default_nettype none

module testbench;
    logic        clk, rst_n, op_valid, op_carry_only, op_byte;
    logic [1:0]  op_format, src_mem_mode, dst_mem_mode;
    logic [2:0]  src_kind, src_reg_id, dst_kind, dst_reg_id;
    logic [15:0] src_value, dst_value, user_sp_in, int_sp_in, result_q;
    logic [7:0]  flags_in, flags_q;
    logic        result_valid_q, wr_user_sp_q, wr_int_sp_q, op_refused_q;
    int          failures = 0;
    int          n_compared = 0;
    wire [3:0]   oszc = {flags_q[5], flags_q[3:2], flags_q[0]};

    add_carry_alu_ops dut_u
    (
        .clk            (clk),
        .rst_n          (rst_n),
        .op_valid       (op_valid),
        .op_carry_only  (op_carry_only),
        .op_byte        (op_byte),
        .op_format      (op_format),
        .src_kind       (src_kind),
        .src_reg_id     (src_reg_id),
        .src_mem_mode   (src_mem_mode),
        .src_value      (src_value),
        .dst_kind       (dst_kind),
        .dst_reg_id     (dst_reg_id),
        .dst_mem_mode   (dst_mem_mode),
        .dst_value      (dst_value),
        .user_sp_in     (user_sp_in),
        .int_sp_in      (int_sp_in),
        .flags_in       (flags_in),
        .result_q       (result_q),
        .result_valid_q (result_valid_q),
        .wr_user_sp_q   (wr_user_sp_q),
        .wr_int_sp_q    (wr_int_sp_q),
        .flags_q        (flags_q),
        .op_refused_q   (op_refused_q)
    );

    // 250 MHz core clock
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // ==========================================
    // shared tasks
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            failures++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // one idle cycle, then one request; answer seen at the next falling edge
    task automatic go(input logic [2:0] sk, input logic [15:0] sv,
                      input logic [2:0] dk, input logic [15:0] dv);
        @(negedge clk);
        src_kind = sk;
        src_value = sv;
        dst_kind = dk;
        dst_value = dv;
        op_valid = 1'b1;
        @(negedge clk);
        op_valid = 1'b0;
    endtask

    task automatic close_out;
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // ==========================================
    // scenarios
    task automatic t_word;
        flags_in = 8'h01;
        go(3'h3, 16'h7fff, 3'h0, 16'h0001);
        chk(result_q, 16'h8000);
        chk(result_valid_q, 1'b1);
        chk(oszc, 4'hc);
        go(3'h0, 16'hffff, 3'h0, 16'h0001);
        chk(oszc, 4'h3);
    endtask

    task automatic t_carry;
        op_carry_only = 1'b1;
        flags_in = 8'hd3;
        go(3'h0, 16'h0000, 3'h0, 16'hffff);
        chk(result_q, 16'h0000);
        chk(flags_q, 8'hd7);
        op_carry_only = 1'b0;
    endtask

    task automatic t_byte;
        op_byte = 1'b1;
        flags_in = 8'h00;
        go(3'h0, 16'hff80, 3'h1, 16'h1234);
        chk(result_q, 16'h12b4);
        go(3'h1, 16'h12f0, 3'h0, 16'h0001);
        chk(result_q, 16'h00f1);
        chk(oszc, 4'h4);
        go(3'h0, 16'h007f, 3'h0, 16'h0001);
        chk(oszc, 4'hc);
        go(3'h1, 16'h0001, 3'h1, 16'h0001);
        chk(op_refused_q, 1'b1);
        chk(result_valid_q, 1'b0);
    endtask

    task automatic t_sp;
        flags_in = 8'h80;
        user_sp_in = 16'h0100;
        go(3'h3, 16'h00fe, 3'h4, 16'h0000);
        chk(result_q, 16'h00fe);
        chk({wr_user_sp_q, wr_int_sp_q}, 2'h2);
        go(3'h0, 16'h0001, 3'h4, 16'h0000);
        chk(op_refused_q, 1'b1);
        flags_in = 8'h00;
        int_sp_in = 16'h0200;
        go(3'h3, 16'h0010, 3'h4, 16'h0000);
        chk(result_q, 16'h0210);
        chk({wr_user_sp_q, wr_int_sp_q}, 2'h1);
    endtask

    task automatic t_fmt;
        op_byte = 1'b0;
        op_format = 2'h1;
        go(3'h3, 16'hfff8, 3'h0, 16'h0010);
        chk(result_q, 16'h0008);
        go(3'h3, 16'h0008, 3'h0, 16'h0010);
        chk(op_refused_q, 1'b1);
        op_format = 2'h2;
        go(3'h3, 16'h0001, 3'h0, 16'h0001);
        chk(op_refused_q, 1'b1);
        op_byte = 1'b1;
        go(3'h0, 16'h0001, 3'h0, 16'h0001);
        chk(op_refused_q, 1'b1);
        src_reg_id = 3'h1;
        go(3'h0, 16'h0001, 3'h0, 16'h0002);
        chk(result_q, 16'h0003);
        dst_mem_mode = 2'h2;
        go(3'h3, 16'h0001, 3'h2, 16'h0001);
        chk(op_refused_q, 1'b1);
        dst_mem_mode = 2'h1;
        go(3'h3, 16'h0005, 3'h2, 16'h0001);
        chk(result_q, 16'h0006);
    endtask

    // hang guard
    initial
    begin
        #100000;
        failures++;
        close_out;
    end

    // main sequence
    initial
    begin
        rst_n = 1'b0;
        {op_valid, op_carry_only, op_byte, op_format, src_kind, src_reg_id,
         src_mem_mode, src_value, dst_kind, dst_reg_id, dst_mem_mode,
         dst_value, user_sp_in, int_sp_in, flags_in} = '0;
        repeat (16) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        t_word;
        t_carry;
        t_byte;
        t_sp;
        t_fmt;
        close_out;
    end
endmodule

`default_nettype wire
